/* File: clkgen_monitor.sv */
// Purpose: port-level checks on clock_gen_top
// Assumes: single clk_sys domain, synchronous reset
// Notes:   bound to every clock_gen_top instance
`timescale 1ns/1ps
`default_nettype none
module clkgen_monitor (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        master_tick,
	input wire logic        cpu_tick,
	input wire logic        sys_tick,
	input wire logic [1:0]  vco_band
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_wr;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
			|=> s_axi_awready && s_axi_wready && s_axi_bvalid;
	endproperty
	a_wr: assert property (p_wr) else $error("write not taken");
	property p_rd;
		s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready && s_axi_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("read not taken");
	property p_pulse;
		s_axi_awready |=> !s_axi_awready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("awready not a pulse");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
	endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data moved");
	property p_cpu;
		cpu_tick |-> $past(master_tick);
	endproperty
	a_cpu: assert property (p_cpu) else $error("cpu tick without master");
	property p_sys;
		sys_tick == cpu_tick;
	endproperty
	a_sys: assert property (p_sys) else $error("sys and cpu differ");
	property p_band;
		vco_band != 2'h3;
	endproperty
	a_band: assert property (p_band) else $error("reserved band");
	c_half: cover property (master_tick ##1 !cpu_tick);
	c_b: cover property (s_axi_bvalid && s_axi_bready);
	c_r: cover property (s_axi_rvalid && s_axi_rready);
endmodule // clkgen_monitor
bind clock_gen_top clkgen_monitor clkgen_monitor_i (.*);
`default_nettype wire

/* File: clkgen_regs.vh */
// Purpose: register map, field layout, reset values, limits and response codes of the master clock generator
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes:   included by clock_gen_top.v
`ifndef CLKGEN_REGS_VH
`define CLKGEN_REGS_VH

`define OFS_CLOCK_GEN_CONFIG   4'h0
`define OFS_SYSTEM_CONFIG_ONE  4'h4
`define OFS_CLOCK_STATUS       4'h8

`define SRC_LSB        0
`define SRC_MSB        1
`define IDIV_LSB       2
`define IDIV_MSB       3
`define ODIV_LSB       4
`define ODIV_MSB       7
`define MUL_LSB        8
`define MUL_MSB        12
`define BAND_LSB       13
`define BAND_MSB       14
`define HALVE_BIT      0

`define SRC_PLL        2'h3
`define BAND_RESERVED  2'h3
`define IDIV_MAX       2'h3
`define ODIV_MAX       4'he

`define RST_SRC        2'h0
`define RST_IDIV       2'h0
`define RST_ODIV       4'h0
`define RST_MUL        5'h00
`define RST_BAND       2'h0
`define RST_HALVE      1'h0

`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* File: clock_gen_top.v */
// Purpose: master clock generation (bypass prescalers or PLL model), cpu and system clock enables
// Assumes: oscillator_input_pin synchronous to clk_sys and slower than clk_sys / 2
// Notes:   derived clocks are one-cycle enables; the PLL is a rate model limited to clk_sys
// Behaviour
// - source select field chooses bypass prescalers or phase locked loop
// - bypass: master rate is oscillator over (input divider+1)*(output divider+1)
// - bypass with both dividers zero: master clock follows oscillator level directly
// - input divider at most 3, output divider at most 14, ratio up to 60
// - select 11 enables PLL: oscillator times (mul+1) over both dividers
// - PLL: VCO output divided by output divider plus one gives master clock
// - VCO band 00,01,10 select ranges; reserved 11 must not be used
// - cpu clock runs at master rate or half, per cpu clock halve bit
// - system clock rate always equals cpu clock rate
`timescale 1ns/1ps
`default_nettype none
`include "clkgen_regs.vh"
module clock_gen_top (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        oscillator_input_pin,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [3:0]  s_axi_araddr,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         master_clock,
	output reg         master_tick,
	output reg         cpu_tick,
	output reg         sys_tick,
	output reg  [1:0]  vco_band
);
	reg  [1:0]  clock_source_select;
	reg  [1:0]  input_divider_value;
	reg  [3:0]  output_divider_value;
	reg  [4:0]  multiplier_value;
	reg         cpu_clock_halve;
	reg         osc_q;
	reg         osc_prev;
	reg  [15:0] period_count;
	reg  [15:0] osc_period;
	reg  [23:0] vco_acc;
	reg         vco_tick;
	reg  [1:0]  next_band;
	reg  [31:0] next_rdata;
	reg  [1:0]  next_rresp;
	wire        osc_rise;
	wire        pll_mode;
	wire        direct;
	wire [23:0] threshold;
	wire        in_tick;
	wire        out_src;
	wire        out_tick;
	wire        halve_tick;
	wire        wr_go;
	wire        rd_go;

	assign osc_rise = osc_q & ~osc_prev;
	assign pll_mode = (clock_source_select == `SRC_PLL);
	assign direct   = ~pll_mode && (input_divider_value == 2'h0) && (output_divider_value == 4'h0);
	// divider plus one is formed in three bits, so a divider of 3 cannot wrap to zero
	assign threshold = osc_period * {5'h00, {1'b0, input_divider_value} + 3'h1};
	assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
	assign rd_go = s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready;

	// bypass input prescaler on oscillator edges
	tick_divider u_in_div (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.tick_in  (osc_rise & ~pll_mode),
		.limit    ({2'h0, input_divider_value}),
		.tick_out (in_tick)
	);

	// output prescaler shared by both paths
	assign out_src = pll_mode ? vco_tick : in_tick;
	tick_divider u_out_div (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.tick_in  (out_src),
		.limit    (output_divider_value),
		.tick_out (out_tick)
	);

	tick_divider u_cpu_div (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.tick_in  (out_tick),
		.limit    ({3'h0, cpu_clock_halve}),
		.tick_out (halve_tick)
	);

	always @(posedge clk_sys) begin
		if (rst) begin
			osc_q        <= 1'b0;
			osc_prev     <= 1'b0;
			period_count <= 16'h0000;
			osc_period   <= 16'h0000;
		end else begin
			osc_q    <= oscillator_input_pin;
			osc_prev <= osc_q;
			if (osc_rise) begin
				osc_period   <= period_count + 16'h0001;
				period_count <= 16'h0000;
			end else if (period_count != 16'hffff) begin
				period_count <= period_count + 16'h0001;
			end
		end
	end

	// vco rate model: (mul+1) per clock against period*(idiv+1)
	// the rate follows the measured period, so it changes in one step when a new period is measured
	always @(posedge clk_sys) begin
		if (rst) begin
			vco_acc  <= 24'h000000;
			vco_tick <= 1'b0;
		end else if (!pll_mode || osc_period == 16'h0000) begin
			vco_acc  <= 24'h000000;
			vco_tick <= 1'b0;
		end else if (vco_acc >= threshold) begin
			// limitation: at most one vco tick per clk_sys, excess rate saturates
			if (vco_acc >= {threshold[22:0], 1'b0})
				vco_acc <= threshold;
			else
				vco_acc <= vco_acc - threshold + {19'h00000, multiplier_value} + 24'h000001;
			vco_tick <= 1'b1;
		end else begin
			vco_acc  <= vco_acc + {19'h00000, multiplier_value} + 24'h000001;
			vco_tick <= 1'b0;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			master_clock <= 1'b0;
			master_tick  <= 1'b0;
			cpu_tick     <= 1'b0;
			sys_tick     <= 1'b0;
		end else begin
			// undivided bypass copies the oscillator level
			if (direct)
				master_clock <= osc_q;
			else if (out_tick)
				master_clock <= ~master_clock;
			master_tick <= out_tick;
			cpu_tick    <= halve_tick;
			sys_tick    <= halve_tick;
		end
	end

	always @* begin
		next_band = s_axi_wdata[`BAND_MSB:`BAND_LSB];
		// reserved band code is not stored
		if (next_band == `BAND_RESERVED)
			next_band = vco_band;
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			clock_source_select  <= `RST_SRC;
			input_divider_value  <= `RST_IDIV;
			output_divider_value <= `RST_ODIV;
			multiplier_value     <= `RST_MUL;
			vco_band             <= `RST_BAND;
			cpu_clock_halve      <= `RST_HALVE;
			s_axi_awready        <= 1'b0;
			s_axi_wready         <= 1'b0;
			s_axi_bvalid         <= 1'b0;
			s_axi_bresp          <= `RESP_OKAY;
		end else begin
			s_axi_awready <= wr_go;
			s_axi_wready  <= wr_go;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `RESP_OKAY;
				case (s_axi_awaddr)
				`OFS_CLOCK_GEN_CONFIG: begin
					if (s_axi_wstrb[0]) begin
						clock_source_select <= s_axi_wdata[`SRC_MSB:`SRC_LSB];
						input_divider_value <= s_axi_wdata[`IDIV_MSB:`IDIV_LSB];
						if (s_axi_wdata[`ODIV_MSB:`ODIV_LSB] > `ODIV_MAX)
							output_divider_value <= `ODIV_MAX;
						else
							output_divider_value <= s_axi_wdata[`ODIV_MSB:`ODIV_LSB];
					end
					if (s_axi_wstrb[1]) begin
						multiplier_value <= s_axi_wdata[`MUL_MSB:`MUL_LSB];
						vco_band         <= next_band;
					end
				end
				`OFS_SYSTEM_CONFIG_ONE: begin
					if (s_axi_wstrb[0])
						cpu_clock_halve <= s_axi_wdata[`HALVE_BIT];
				end
				`OFS_CLOCK_STATUS: begin
					s_axi_bresp <= `RESP_OKAY;
				end
				default: begin
					s_axi_bresp <= `RESP_SLVERR;
				end
				endcase
			end
		end
	end

	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `RESP_OKAY;
		case (s_axi_araddr)
		`OFS_CLOCK_GEN_CONFIG: begin
			next_rdata[`SRC_MSB:`SRC_LSB]   = clock_source_select;
			next_rdata[`IDIV_MSB:`IDIV_LSB] = input_divider_value;
			next_rdata[`ODIV_MSB:`ODIV_LSB] = output_divider_value;
			next_rdata[`MUL_MSB:`MUL_LSB]   = multiplier_value;
			next_rdata[`BAND_MSB:`BAND_LSB] = vco_band;
		end
		`OFS_SYSTEM_CONFIG_ONE: begin
			next_rdata[`HALVE_BIT] = cpu_clock_halve;
		end
		`OFS_CLOCK_STATUS: begin
			next_rdata[0]     = pll_mode;
			next_rdata[1]     = master_clock;
			next_rdata[31:16] = osc_period;
		end
		default: begin
			next_rresp = `RESP_SLVERR;
		end
		endcase
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= rd_go;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= next_rdata;
				s_axi_rresp  <= next_rresp;
			end
		end
	end
endmodule // clock_gen_top
`default_nettype wire

/* File: clock_gen_top_tb.sv */
// Purpose: self-checking bench for clock_gen_top
// Assumes: oscillator period 6 cycles, high for 2
// Notes:   rates judged by counting ticks over fixed windows
`timescale 1ns/1ps
`default_nettype none
module clock_gen_top_tb;
	logic        clk_sys = 0;
	logic        rst = 1;
	logic        osc;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0]  awaddr = 0, araddr = 0, wstrb = 0;
	logic [31:0] wdata = 0, rdata;
	logic [1:0]  bresp, rresp, band;
	logic        awready, wready, bvalid, arready, rvalid, mclk, mtick, ctick, stick;
	int          mismatches = 0, checks_done = 0;
	int          sys_sum = 0;
	always #20 clk_sys = ~clk_sys;
	osc_source osc_source_i (.clk_sys(clk_sys), .osc_pin(osc));
	clock_gen_top clock_gen_top_i (.clk_sys(clk_sys), .rst(rst), .oscillator_input_pin(osc),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.master_clock(mclk), .master_tick(mtick), .cpu_tick(ctick), .sys_tick(stick),
		.vco_band(band));
	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task near(input int g, input int e, input int t, input string m);
		chk(g >= e - t && g <= e + t, m);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int k;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		if (k == 50) begin
			chk(1'b0, "write timeout");
			give_verdict;
		end
		@(posedge clk_sys);
	endtask
	task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		if (k == 50) begin
			chk(1'b0, "read timeout");
			give_verdict;
		end
		@(posedge clk_sys);
	endtask
	task cnt(input int n, output int m, output int c, output int h);
		m = 0;
		c = 0;
		h = 0;
		sys_sum = 0;
		repeat (n) begin
			@(posedge clk_sys);
			m += mtick;
			c += ctick;
			h += mclk;
			sys_sum += stick;
			// an unknown tick would count as zero and slip past the rate checks
			if ($isunknown({mtick, ctick, stick, mclk})) chk(1'b0, "unknown clock output");
		end
	endtask
	task t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		rd(4'h0, d, r);
		chk(d === 32'h0 && r === 2'h0, "config reset");
		wr(4'hc, 32'h1, 4'hf, r);
		chk(r === 2'h2, "unmapped write");
		rd(4'hc, d, r);
		chk(d === 32'h0 && r === 2'h2, "unmapped read");
	endtask
	task t_bypass;
		int m, c, h, s;
		logic [1:0] r;
		// select codes 00, 01 and 10 all mean bypass; ratio 2 x 3
		for (s = 0; s < 3; s++) begin
			wr(4'h0, 32'h24 | s, 4'h1, r);
			cnt(36, m, c, h);
			cnt(720, m, c, h);
			near(m, 20, 1, "bypass rate");
		end
	endtask
	task t_limit;
		int m, c, h;
		logic [31:0] d;
		logic [1:0]  r;
		wr(4'h0, 32'hfc, 4'h1, r);
		rd(4'h0, d, r);
		chk(d === 32'hec, "divider clamp");
		cnt(360, m, c, h);
		cnt(1800, m, c, h);
		near(m, 5, 1, "lowest rate");
	endtask
	task t_follow;
		int m, c, h;
		logic [1:0] r;
		wr(4'h0, 32'h0, 4'h1, r);
		cnt(12, m, c, h);
		cnt(600, m, c, h);
		near(h, 200, 4, "duty follows");
	endtask
	task t_halve;
		int m, c, h;
		logic [1:0] r;
		wr(4'h0, 32'h24, 4'h1, r);
		wr(4'h4, 32'h1, 4'h1, r);
		cnt(720, m, c, h);
		near(c * 2, m, 2, "cpu halved");
		chk(sys_sum == c, "sys differs from cpu halved");
		wr(4'h4, 32'h0, 4'h1, r);
		cnt(36, m, c, h);
		cnt(720, m, c, h);
		near(c, m, 1, "cpu full");
		chk(sys_sum == c && c > 0, "sys differs from cpu full");
	endtask
	task t_pll;
		int m, c, h;
		logic [31:0] d;
		logic [1:0]  r;
		// times 3, over 1 x 2: master at 1.5 x oscillator
		wr(4'h0, 32'h213, 4'h3, r);
		cnt(100, m, c, h);
		cnt(800, m, c, h);
		near(m, 200, 4, "pll rate");
		// times 12, over 4 x 1: largest input divider, master at half the clock rate
		wr(4'h0, 32'hb0f, 4'h3, r);
		cnt(100, m, c, h);
		cnt(400, m, c, h);
		near(m, 200, 4, "pll rate, input divider 3");
		rd(4'h8, d, r);
		chk(d[0] === 1'b1, "pll status");
		chk(d[31:16] === 16'h0006, "measured oscillator period");
	endtask
	task t_band;
		int b;
		logic [1:0] r;
		for (b = 0; b < 3; b++) begin
			wr(4'h0, b << 13, 4'h2, r);
			repeat (2) @(posedge clk_sys);
			chk(band === 2'(b), "band");
		end
		wr(4'h0, 32'h6000, 4'h2, r);
		repeat (2) @(posedge clk_sys);
		chk(band === 2'h2, "reserved band kept");
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		t_regs;
		t_bypass;
		t_limit;
		t_follow;
		t_halve;
		t_pll;
		t_band;
		give_verdict;
	end
endmodule // clock_gen_top_tb
`default_nettype wire

/* File: osc_source.sv */
// Purpose: free-running external clock on the oscillator pin
// Assumes: period of HIGH + LOW clk_sys cycles
// Notes:   uneven duty so duty reproduction is visible
`timescale 1ns/1ps
`default_nettype none
module osc_source #(parameter int HIGH = 2, parameter int LOW = 4) (
	input  wire logic clk_sys,
	output var  logic osc_pin
);
	int n = 0;
	initial osc_pin = 1'b0;
	always @(posedge clk_sys) begin
		n <= (n == HIGH + LOW - 1) ? 0 : n + 1;
		osc_pin <= (n < HIGH);
	end
endmodule // osc_source
`default_nettype wire

/* File: tick_divider.v */
// Purpose: divide a stream of one-cycle enable pulses by (limit + 1)
// Assumes: tick_in is a one-cycle pulse in the clk_sys domain
// Notes:   tick_out is registered, one cycle behind the pulse that completes the count
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
	input  wire       clk_sys,
	input  wire       rst,
	input  wire       tick_in,
	input  wire [3:0] limit,
	output reg        tick_out
);
	reg [3:0] count;

	always @(posedge clk_sys) begin
		if (rst) begin
			count    <= 4'h0;
			tick_out <= 1'b0;
		end else begin
			tick_out <= 1'b0;
			if (tick_in) begin
				// a limit lowered below the running count still wraps at once
				if (count >= limit) begin
					count    <= 4'h0;
					tick_out <= 1'b1;
				end else begin
					count <= count + 4'h1;
				end
			end
		end
	end
endmodule // tick_divider
`default_nettype wire
